// ### ddr_lane.sv
// Purpose: byte lane placement and write masking on an 8-bit ddr link
// Assumes: link clock, select and pins are sampled by the 200 MHz clock;
//          phase and latency levels come from neighbouring logic
// Notes:   link clock edges are found by oversampling, so the link clock
//          must run well below a quarter of the system clock
//
// Overview of operation
// - A read moves one 16-bit word per link clock cycle as two bytes.
// - On reads the upper byte goes out while the strobe is high.
// - On reads the lower byte goes out while the strobe is low.
// - On writes the upper byte is taken at the rising link edge, lower at falling.
// - Register space uses the same big-endian placement as memory.
// - In writes with latency the strobe/mask acts as a per-byte mask.
// - In zero-latency writes every word is stored whole, no masking.
// - In zero-latency writes the device drives the strobe/mask low.
// - A byte sent with mask high is dropped, with mask low it is stored.
`timescale 1ns/1ps
`include "ddr_lane_map.svh"

module ddr_lane (
  // system clock and reset
  input  wire logic                 i_clk_sys,
  input  wire logic                 i_arst_n,
  // link pins
  input  wire logic                 i_link_ck,
  input  wire logic                 i_link_sel_n,
  input  wire logic [7:0]           i_dq,
  output logic      [7:0]           o_dq,
  output logic                      o_dq_oe,
  input  wire logic                 i_strobe_or_write_mask,
  output logic                      o_strobe_or_write_mask,
  output logic                      o_strobe_or_write_mask_oe,
  // phase control from neighbouring logic
  input  wire logic                 i_rd_phase,
  input  wire logic                 i_wr_phase,
  input  wire logic                 i_wr_zero_lat,
  // read word source
  input  wire ddr_lane_pkg::word_t  i_rd_word,
  output logic                      o_rd_take,
  // write word sink
  output ddr_lane_pkg::word_t       o_wr_word,
  output logic      [1:0]           o_wr_be,
  output logic                      o_wr_valid
);

  logic [`LANE_SYNC_W-1:0] pins_s;
  logic                    ck_s;
  logic                    sel_n_s;
  ddr_lane_pkg::byte_t     dq_s;
  logic                    mask_s;
  logic                    ck_d_r;
  logic                    rise;
  logic                    fall;

  ddr_lane_pkg::phase_t    phase_r;
  ddr_lane_pkg::phase_t    phase_nxt;
  ddr_lane_pkg::byte_t     dq_r;
  ddr_lane_pkg::byte_t     dq_nxt;
  ddr_lane_pkg::byte_t     lo_r;
  ddr_lane_pkg::byte_t     lo_nxt;
  logic                    strobe_r;
  logic                    strobe_nxt;
  ddr_lane_pkg::byte_t     hi_r;
  ddr_lane_pkg::byte_t     hi_nxt;
  logic                    hi_mask_r;
  logic                    hi_mask_nxt;
  logic                    half_r;
  logic                    half_nxt;
  ddr_lane_pkg::word_t     wr_word_r;
  ddr_lane_pkg::word_t     wr_word_nxt;
  logic [1:0]              wr_be_r;
  logic [1:0]              wr_be_nxt;
  logic                    wr_valid_r;
  logic                    wr_valid_nxt;

  // all link pins pass two flops together, keeping data and clock aligned
  lane_sync #(
    .W (`LANE_SYNC_W)
  ) u_sync (
    .i_clk_sys (i_clk_sys),
    .i_arst_n  (i_arst_n),
    .i_async   ({i_link_ck, i_link_sel_n, i_dq, i_strobe_or_write_mask}),
    .o_sync    (pins_s)
  );

  assign {ck_s, sel_n_s, dq_s, mask_s} = pins_s;

  // edge finder on the synchronised link clock
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ck_d_r <= `LANE_BIT_LO;
    end else begin
      ck_d_r <= ck_s;
    end
  end

  assign rise = ck_s & ~ck_d_r;
  assign fall = ~ck_s & ck_d_r;

  // phase selection; a high select always ends the transfer
  always_comb begin
    phase_nxt = ddr_lane_pkg::PH_IDLE;
    if (!sel_n_s) begin
      if (i_rd_phase) begin
        phase_nxt = ddr_lane_pkg::PH_READ;
      end else if (i_wr_phase) begin
        phase_nxt = ddr_lane_pkg::PH_WRITE;
      end
    end
  end

  // read lanes: byte a out with strobe high, byte b with strobe low
  // the word is taken whole at the rise so both halves come from one word
  always_comb begin
    dq_nxt     = dq_r;
    lo_nxt     = lo_r;
    strobe_nxt = strobe_r;
    o_rd_take  = `LANE_BIT_LO;
    case (phase_r)
      ddr_lane_pkg::PH_READ: begin
        if (rise) begin
          dq_nxt     = i_rd_word[`LANE_HI_MSB:`LANE_HI_LSB];
          lo_nxt     = i_rd_word[`LANE_LO_MSB:`LANE_LO_LSB];
          strobe_nxt = `LANE_BIT_HI;
          o_rd_take  = `LANE_BIT_HI;
        end else if (fall) begin
          dq_nxt     = lo_r;
          strobe_nxt = `LANE_BIT_LO;
        end
      end
      ddr_lane_pkg::PH_IDLE,
      ddr_lane_pkg::PH_WRITE: begin
        strobe_nxt = `LANE_BIT_LO; // strobe rests low outside reads
      end
      default: begin
        strobe_nxt = `LANE_BIT_LO;
      end
    endcase
  end

  // write lanes: byte a at the rising edge, byte b at the falling edge
  // sampling at the edges of the oversampled clock relies on centred data
  always_comb begin
    hi_nxt       = hi_r;
    hi_mask_nxt  = hi_mask_r;
    half_nxt     = half_r;
    wr_word_nxt  = wr_word_r;
    wr_be_nxt    = wr_be_r;
    wr_valid_nxt = `LANE_BIT_LO;
    case (phase_r)
      ddr_lane_pkg::PH_WRITE: begin
        if (rise) begin
          hi_nxt      = dq_s;
          // zero latency: the mask pin is not the host's, ignore it
          hi_mask_nxt = i_wr_zero_lat ? `LANE_BIT_LO : mask_s;
          half_nxt    = `LANE_BIT_HI;
        end else if (fall && half_r) begin
          wr_word_nxt = {hi_r, dq_s};
          wr_be_nxt[`LANE_BE_HI] = ~hi_mask_r;
          wr_be_nxt[`LANE_BE_LO] = i_wr_zero_lat ? `LANE_BIT_HI
                                                 : ~mask_s;
          wr_valid_nxt = `LANE_BIT_HI;
          half_nxt     = `LANE_BIT_LO;
        end
      end
      ddr_lane_pkg::PH_IDLE,
      ddr_lane_pkg::PH_READ: begin
        half_nxt = `LANE_BIT_LO; // a lone byte a at the end is dropped
      end
      default: begin
        half_nxt = `LANE_BIT_LO;
      end
    endcase
  end

  // registers of both lane groups
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      phase_r    <= ddr_lane_pkg::PH_IDLE;
      dq_r       <= `LANE_DQ_RST;
      lo_r       <= `LANE_DQ_RST;
      strobe_r   <= `LANE_BIT_LO;
      hi_r       <= `LANE_DQ_RST;
      hi_mask_r  <= `LANE_BIT_LO;
      half_r     <= `LANE_BIT_LO;
      wr_word_r  <= `LANE_WORD_RST;
      wr_be_r    <= `LANE_BE_RST;
      wr_valid_r <= `LANE_BIT_LO;
    end else begin
      phase_r    <= phase_nxt;
      dq_r       <= dq_nxt;
      lo_r       <= lo_nxt;
      strobe_r   <= strobe_nxt;
      hi_r       <= hi_nxt;
      hi_mask_r  <= hi_mask_nxt;
      half_r     <= half_nxt;
      wr_word_r  <= wr_word_nxt;
      wr_be_r    <= wr_be_nxt;
      wr_valid_r <= wr_valid_nxt;
    end
  end

  // pin drivers; with latency the strobe is left to the host's mask
  assign o_dq    = dq_r;
  assign o_dq_oe = (phase_r == ddr_lane_pkg::PH_READ);
  assign o_strobe_or_write_mask = strobe_r;
  assign o_strobe_or_write_mask_oe =
      (phase_r == ddr_lane_pkg::PH_READ) ||
      ((phase_r == ddr_lane_pkg::PH_WRITE) && i_wr_zero_lat);
  assign o_wr_word  = wr_word_r;
  assign o_wr_be    = wr_be_r;
  assign o_wr_valid = wr_valid_r;

  // checks on the behaviour of both lane groups
  sequence rise_in_read_s;
    (phase_r == ddr_lane_pkg::PH_READ) && rise;
  endsequence

  sequence fall_in_read_s;
    (phase_r == ddr_lane_pkg::PH_READ) && fall && !rise;
  endsequence

  sequence pair_close_s;
    (phase_r == ddr_lane_pkg::PH_WRITE) && fall && half_r;
  endsequence

  rd_word_pace_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_arst_n)
    rise_in_read_s |-> o_rd_take
  ) else $error("read word not taken at link rise");

  rd_upper_byte_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_arst_n)
    rise_in_read_s |=>
      (o_dq == $past(i_rd_word[`LANE_HI_MSB:`LANE_HI_LSB])) &&
      o_strobe_or_write_mask && o_dq_oe
  ) else $error("upper read byte not out with strobe high");

  rd_lower_byte_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_arst_n)
    // a bounded window keeps the lower half tied to the word of its rise
    rise_in_read_s ##[1:40] fall_in_read_s |=>
      (o_dq == $past(lo_r)) && !o_strobe_or_write_mask
  ) else $error("lower read byte not out with strobe low");

  wr_pair_order_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_arst_n)
    pair_close_s |=> o_wr_valid &&
                     (o_wr_word[`LANE_LO_MSB:`LANE_LO_LSB] == $past(dq_s)) &&
                     (o_wr_word[`LANE_HI_MSB:`LANE_HI_LSB] == $past(hi_r))
  ) else $error("write bytes paired in wrong order");

  wr_lo_mask_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_arst_n)
    pair_close_s and !i_wr_zero_lat |=>
      (o_wr_be[`LANE_BE_LO] == !$past(mask_s))
  ) else $error("lower byte enable does not follow mask");

  wr_hi_mask_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_arst_n)
    pair_close_s and !i_wr_zero_lat |=>
      (o_wr_be[`LANE_BE_HI] == !$past(hi_mask_r))
  ) else $error("upper byte enable does not follow mask");

  zl_full_word_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_arst_n)
    pair_close_s and i_wr_zero_lat and $past(i_wr_zero_lat, 4) |=>
      (o_wr_be == `LANE_BE_ALL)
  ) else $error("zero latency write was masked");

  zl_drive_low_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_arst_n)
    (phase_r == ddr_lane_pkg::PH_WRITE) && i_wr_zero_lat |->
      o_strobe_or_write_mask_oe && !o_strobe_or_write_mask
  ) else $error("zero latency strobe not driven low");

  mask_released_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_arst_n)
    (phase_r == ddr_lane_pkg::PH_WRITE) && !i_wr_zero_lat |->
      !o_strobe_or_write_mask_oe && !o_dq_oe
  ) else $error("device drives pins during masked write");

  wr_valid_pulse_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_arst_n)
    o_wr_valid |=> !o_wr_valid
  ) else $error("write valid longer than one cycle");

endmodule

// ### ddr_lane_map.svh
// Purpose: named constants for the ddr byte lane placement block
// Assumes: included by bare name from the package and the design files
// Notes:   definitions only
`ifndef DDR_LANE_MAP_SVH
`define DDR_LANE_MAP_SVH

// word field positions: byte a is the upper half, byte b the lower
`define LANE_HI_MSB   15
`define LANE_HI_LSB   8
`define LANE_LO_MSB   7
`define LANE_LO_LSB   0

// byte enable positions inside the two-bit enable word
`define LANE_BE_HI    1
`define LANE_BE_LO    0

// reset and idle values
`define LANE_DQ_RST   8'h00
`define LANE_WORD_RST 16'h0000
`define LANE_BE_RST   2'h0
`define LANE_BE_ALL   2'h3
`define LANE_BIT_LO   1'b0
`define LANE_BIT_HI   1'b1

// synchroniser width: link clock, select, eight data bits, strobe/mask
`define LANE_SYNC_W   11

`endif

// ### ddr_lane_pkg.sv
// Purpose: shared types of the ddr byte lane placement block
// Assumes: nothing beyond the map header
// Notes:   types only, constants live in the map header
`include "ddr_lane_map.svh"

package ddr_lane_pkg;

  // transfer phase of the data lines
  typedef enum logic [1:0] {
    PH_IDLE,
    PH_READ,
    PH_WRITE
  } phase_t;

  typedef logic [15:0] word_t;
  typedef logic [7:0]  byte_t;

endpackage

// ### lane_sync.sv
// Purpose: two-flop synchroniser for pins from outside the clock domain
// Assumes: one system clock, asynchronous active-low reset
// Notes:   the first stage is read only by the second stage
`timescale 1ns/1ps

module lane_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         i_clk_sys,
  input  wire logic         i_arst_n,
  // asynchronous pins in, synchronised levels out
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  // two stages; the outputs of stage one feed stage two and nothing else
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= i_async;
      sync_r <= meta_r;
    end
  end

  assign o_sync = sync_r;

endmodule

// ### host_model.sv
// Purpose: host side of the link: link clock, select, write data and mask
// Assumes: link clock period 125 ns, clock idle low between frames
// Notes:   a released line is shown by the bench as its inverted last value
`timescale 1ns/1ps

module host_model (
  // resolved pins as the host sees them
  input  wire logic [7:0] i_dq,
  input  wire logic       i_mask,
  // host drivers and enables
  output logic            o_link_ck,
  output logic            o_sel_n,
  output logic      [7:0] o_dq,
  output logic            o_dq_oe,
  output logic            o_mask,
  output logic            o_mask_oe
);
  // idle bus: no frame, nothing driven
  initial begin
    o_link_ck = 1'b0;
    o_sel_n   = 1'b1;
    o_dq      = 8'h00;
    o_dq_oe   = 1'b0;
    o_mask    = 1'b0;
    o_mask_oe = 1'b0;
  end

  // open or close a frame while the link clock is still
  task automatic frame(input logic open);
    o_sel_n   = ~open;
    o_dq_oe   = 1'b0;
    o_mask_oe = 1'b0;
    #40;
  endtask

  // mask driven to a valid low before the first masked data
  task automatic premask();
    o_mask_oe = 1'b1;
    o_mask    = 1'b0;
    #30;
  endtask

  // one write word, data centred between the link edges
  task automatic wr(input logic [15:0] w, input logic [1:0] m,
                    input logic zl);
    o_dq_oe   = 1'b1;
    o_mask_oe = ~zl;
    o_dq      = w[15:8];
    o_mask    = m[1];
    #31 o_link_ck = 1'b1;
    #31 o_dq = w[7:0];
    o_mask = m[0];
    #32 o_link_ck = 1'b0;
    #31;
  endtask

  // one read cycle: sample both halves well after each link edge
  task automatic rd(output logic [7:0] a, b, output logic sa, sb);
    o_dq_oe   = 1'b0;
    o_link_ck = 1'b1;
    #50 a = i_dq;
    sa = i_mask;
    #12 o_link_ck = 1'b0;
    #50 b = i_dq;
    sb = i_mask;
    #13;
  endtask
endmodule

// ### test_ddr_lane.sv
// Purpose: self-checking bench for the byte lane placement block
// Assumes: 200 MHz system clock, host model makes the link clock
// Notes:   random words come from a 16-bit lfsr started at 99
`timescale 1ns/1ps

module test_ddr_lane;
  logic              clk_sys = 1'b0;
  logic              arst_n, rd_phase, wr_phase, wr_zero_lat;
  logic              ck, sel_n, dq_oe, h_dq_oe, mk_o, mk_oe, h_mk;
  logic              h_mk_oe, rd_take, wr_valid;
  logic        [7:0] dq_o, h_dq;
  logic        [1:0] wr_be;
  ddr_lane_pkg::word_t rd_word, wr_word;
  wire logic   [7:0] dq_pin;
  wire logic         mk_pin;
  logic       [15:0] lfsr = 16'h0063;
  logic       [17:0] got_q[$], exp_q[$];
  int                fails, compares, takes, cycles;

  // pins resolved from both parties' enables
  assign dq_pin = dq_oe ? dq_o : (h_dq_oe ? h_dq : ~h_dq);
  assign mk_pin = mk_oe ? mk_o : (h_mk_oe ? h_mk : ~h_mk);

  always #2.5 clk_sys = ~clk_sys;

  ddr_lane dut_u (.i_clk_sys(clk_sys), .i_arst_n(arst_n), .i_link_ck(ck),
    .i_link_sel_n(sel_n), .i_dq(dq_pin), .o_dq(dq_o), .o_dq_oe(dq_oe),
    .i_strobe_or_write_mask(mk_pin), .o_strobe_or_write_mask(mk_o),
    .o_strobe_or_write_mask_oe(mk_oe), .i_rd_phase(rd_phase),
    .i_wr_phase(wr_phase), .i_wr_zero_lat(wr_zero_lat),
    .i_rd_word(rd_word), .o_rd_take(rd_take), .o_wr_word(wr_word),
    .o_wr_be(wr_be), .o_wr_valid(wr_valid));

  host_model host_u (.i_dq(dq_pin), .i_mask(mk_pin), .o_link_ck(ck),
    .o_sel_n(sel_n), .o_dq(h_dq), .o_dq_oe(h_dq_oe), .o_mask(h_mk),
    .o_mask_oe(h_mk_oe));

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic check(input logic [23:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // count read takes, collect written words, cut a hang short
  always @(posedge clk_sys) begin
    cycles++;
    if (rd_take === 1'b1)
      takes++;
    if (wr_valid === 1'b1)
      got_q.push_back({wr_word, wr_be});
    if (cycles == 4000) begin
      fails++;
      stop_test();
    end
  end

  initial begin
    logic [7:0] a, b;
    logic       sa, sb;
    logic [1:0] m;
    {arst_n, rd_phase, wr_phase, wr_zero_lat} = 4'h0;
    rd_word = 16'h0000;
    repeat (6) @(posedge clk_sys);
    check({dq_o, dq_oe, mk_oe, mk_o, rd_take, wr_valid}, 24'h0);
    #1 arst_n = 1'b1;
    repeat (3) @(posedge clk_sys);
    // link edges outside any phase must be ignored
    host_u.frame(1'b1);
    host_u.rd(a, b, sa, sb);
    check(24'(takes + got_q.size()), 24'h0);
    $display("test idle done");
    @(posedge clk_sys) #1 rd_phase = 1'b1;
    for (int i = 0; i < 12; i++) begin
      lfsr = lfsr_next(lfsr);
      @(posedge clk_sys) #1 rd_word = (i < 2) ? {2{8'hff}} >> (8 * i) : lfsr;
      host_u.rd(a, b, sa, sb);
      check({a, b}, rd_word);
      check({sa, sb, dq_oe}, 3'h5);
    end
    check(24'(takes), 24'd12);
    @(posedge clk_sys) #1 rd_phase = 1'b0;
    host_u.frame(1'b0);
    $display("test read done");
    // masked write first, then zero-latency write
    for (int z = 0; z < 2; z++) begin
      host_u.frame(1'b1);
      @(posedge clk_sys) #1 wr_phase = 1'b1;
      wr_zero_lat = z[0];
      if (z == 0)
        host_u.premask();
      for (int i = 0; i < 10; i++) begin
        lfsr = lfsr_next(lfsr);
        m = (i == 0) ? 2'h2 : (i == 1) ? 2'h1 : lfsr[1:0];
        host_u.wr(lfsr, m, z[0]);
        exp_q.push_back({lfsr, z[0] ? 2'h3 : ~m});
        check(mk_oe, z[0]);
        if (z == 1)
          check(mk_o, 1'b0);
      end
      @(posedge clk_sys) #1 wr_phase = 1'b0;
      host_u.frame(1'b0);
    end
    check(24'(got_q.size()), 24'd20);
    foreach (exp_q[k])
      check(got_q[k], exp_q[k]);
    $display("test write done");
    stop_test();
  end
endmodule
